// ==== verilog/dvf_defs.svh ====
// Offsets, field positions, reset values and constants of the volume/filter control slice
// Assumes byte-wide register access from the serial control port front end
`ifndef DVF_DEFS_SVH
`define DVF_DEFS_SVH
`define DVF_OFS_ATTEN_A 8'h0f
`define DVF_OFS_ATTEN_B 8'h10
`define DVF_OFS_TRIM0 8'h11
`define DVF_OFS_TRIM3 8'h14
`define DVF_OFS_SRC_CFG 8'h15
`define DVF_OFS_C2_LO 8'h16
`define DVF_OFS_C2_HI 8'h17
`define DVF_OFS_C3_LO 8'h18
`define DVF_OFS_C3_HI 8'h19
`define DVF_OFS_COEF_ADR 8'h1a
`define DVF_RST_ATTEN 8'h00
`define DVF_RST_TRIM 32'h7fff_ffff
`define DVF_RST_SRC_CFG 8'h00
`define DVF_RST_COEF 16'h0000
`define DVF_RST_COEF_ADR 8'h00
`define DVF_BIT_OSF_SKIP 0
`define DVF_BIT_IIR_SKIP 2
`define DVF_FLD_LOW_LSB 4
`define DVF_FLD_HIGH_LSB 6
`define DVF_BIT_STAGE 7
`define DVF_GPIO_CFG_SRC 4'h9
`define DVF_NUM_GPIO 2
`define DVF_STEPS_PER_6DB 8'h0c
`define DVF_SAMPLE_FRAC 23
`define DVF_COEF_FRAC 15
`endif

// ==== verilog/dvf_pkg.sv ====
// Types shared by the volume/filter control slice
// Assumes dvf_defs.svh is on the include path
package dvf_pkg;
    typedef enum logic [1:0] {
        DVF_SRC_I2S = 2'h0,
        DVF_SRC_SPDIF = 2'h1,
        DVF_SRC_RSVD = 2'h2,
        DVF_SRC_DSD = 2'h3
    } dvf_src_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic write;
        logic read;
    } dvf_reg_req_s;
    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
        logic valid;
    } dvf_sample_s;
    typedef struct packed {
        logic stage;
        logic [6:0] index;
        logic [23:0] data;
        logic we;
    } dvf_coef_wr_s;
endpackage : dvf_pkg

// ==== verilog/dvf_control.sv ====
// Volume, full-scale gain, source select, filter skip and THD compensation control
// Assumes a byte register port from the control interface on clk, async GPIO pins
// How it works
// RULE1: Each attenuation byte gives 0 to -127.5 dB in 0.5 dB steps, resets 0.
// RULE2: Attenuator A drives left, B right, unless channel mapping swaps them.
// RULE3: Signed 32-bit full-scale word is the 0 dB level, resets to 7fffffff.
// RULE4: Full-scale word spans four bytes, highest address holds the top byte.
// RULE5: Host never writes the full-scale word above the largest positive value.
// RULE6: Selector pin low picks source from the low-level field.
// RULE7: Selector pin high picks source from the high-level field.
// RULE8: A GPIO selects source only when its pin configuration equals nine.
// RULE9: With several selector GPIOs, only the lowest numbered one counts.
// RULE10: Host configures at most one GPIO as source selector; the bench sets both GPIOs to nine once to check RULE9.
// RULE11: IIR-skip bit 2 set bypasses the IIR filter, resets clear.
// RULE12: Oversampling-skip bit 0 set bypasses the 8x FIR filter, resets clear.
// RULE13: With 8x filter bypassed, source must supply 8x oversampled data.
// RULE14: Host writes reserved bits of the select/skip register as zero.
// RULE15: Second-harmonic coefficient is signed 16 bits, high byte upper address.
// RULE16: Third-harmonic coefficient is signed 16 bits, high byte upper address.
// RULE17: Address bit 7 picks stage one (128 taps) or stage two (16 taps).
// RULE18: Address bits 6..0 give the index of the next custom coefficient.
// RULE19: Compensation enabled adds x squared times c2 and x cubed times c3.
// RULE20: A 24-bit custom coefficient goes to the stage and index held.
// RULE21: Channel gain is full-scale word scaled by its attenuation per sample.
`timescale 1ns/1ps
`default_nettype none
`include "dvf_defs.svh"
module dvf_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire dvf_pkg::dvf_reg_req_s regReq,
    output logic [7:0] regRdData,
    // Settings held elsewhere in the device
    input wire logic swapChannels,
    input wire logic thdBypass,
    input wire logic [3:0] gpioCfg [`DVF_NUM_GPIO],
    input wire logic [`DVF_NUM_GPIO-1:0] gpioPin,
    // Custom coefficient data from the coefficient registers
    input wire logic [23:0] coefWrData,
    input wire logic coefWrite,
    output dvf_pkg::dvf_coef_wr_s coefWr,
    // Path control
    output dvf_pkg::dvf_src_e selectedSource,
    output logic sourceByGpio,
    output logic iirBypass,
    output logic osfBypass,
    // Sample stream
    input wire dvf_pkg::dvf_sample_s sampleIn,
    output dvf_pkg::dvf_sample_s sampleOut
);
    import dvf_pkg::*;

    typedef struct packed {
        logic [7:0] attenA;
        logic [7:0] attenB;
        logic [31:0] trim;
        logic [7:0] srcCfg;
        logic [15:0] c2;
        logic [15:0] c3;
        logic [7:0] coefAdr;
        logic [7:0] rdData;
        logic [`DVF_NUM_GPIO-1:0] pinMeta;
        logic [`DVF_NUM_GPIO-1:0] pinSync;
        dvf_src_e src;
        logic byGpio;
        logic [31:0] gainL;
        logic [31:0] gainR;
        logic signed [23:0] midL;
        logic signed [23:0] midR;
        logic midValid;
        dvf_sample_s out;
        dvf_coef_wr_s coef;
    } dvf_state_s;

    dvf_state_s state;
    dvf_state_s next_state;

    // 0.5 dB step factors within one 6 dB octave, 16-bit fraction
    function automatic logic [15:0] step_frac(input logic [3:0] k);
        unique case (k)
            4'h0: step_frac = 16'hffff;
            4'h1: step_frac = 16'hf1ae;
            4'h2: step_frac = 16'he429;
            4'h3: step_frac = 16'hd766;
            4'h4: step_frac = 16'hcb59;
            4'h5: step_frac = 16'hbff9;
            4'h6: step_frac = 16'hb53c;
            4'h7: step_frac = 16'hab18;
            4'h8: step_frac = 16'ha186;
            4'h9: step_frac = 16'h987d;
            4'ha: step_frac = 16'h8ff6;
            4'hb: step_frac = 16'h87e8;
            default: step_frac = 16'h0000;
        endcase
    endfunction : step_frac

    // Full-scale word attenuated by code x 0.5 dB; every 12 codes halve it
    function automatic logic [31:0] atten_gain(input logic [31:0] fs, input logic [7:0] code);
        logic [47:0] prod;
        logic [7:0] oct;
        logic [7:0] rem;
        oct = code / `DVF_STEPS_PER_6DB;
        rem = code % `DVF_STEPS_PER_6DB;
        prod = fs * step_frac(rem[3:0]);
        atten_gain = prod[47:16] >> oct;
    endfunction : atten_gain

    // Signed sample times a non-negative Q1.31 gain
    function automatic logic signed [23:0] apply_gain(input logic signed [23:0] x,
                                                       input logic [31:0] g);
        logic signed [56:0] p;
        p = x * $signed({1'b0, g});
        apply_gain = p[54:31];
    endfunction : apply_gain

    // x + x^2*c2 + x^3*c3 in Q1.23 samples and Q1.15 coefficients, saturated
    function automatic logic signed [23:0] thd_comp(input logic signed [23:0] x,
                                                     input logic [15:0] c2,
                                                     input logic [15:0] c3);
        logic signed [47:0] sq;
        logic signed [47:0] cu;
        logic signed [39:0] t2;
        logic signed [39:0] t3;
        logic signed [25:0] sum;
        sq = x * x;
        // Square is never negative; the zero bit keeps the products signed
        cu = $signed({1'b0, sq[46:23]}) * x;
        t2 = $signed({1'b0, sq[46:23]}) * $signed(c2);
        t3 = $signed(cu[46:23]) * $signed(c3);
        sum = 26'(x) + 26'(t2 >>> `DVF_COEF_FRAC) + 26'(t3 >>> `DVF_COEF_FRAC);
        if (sum > 26'sh07f_ffff) thd_comp = 24'sh7f_ffff;
        else if (sum < -26'sh080_0000) thd_comp = -24'sh80_0000;
        else thd_comp = sum[23:0];
    endfunction : thd_comp

    always_comb begin
        logic selHit;
        logic selLevel;
        logic [1:0] field;
        selHit = 1'b0;
        selLevel = 1'b0;
        field = 2'h0;
        next_state = state;
        next_state.pinMeta = gpioPin;
        next_state.pinSync = state.pinMeta;
        next_state.coef.we = 1'b0;

        if (regReq.write) begin
            unique case (regReq.addr)
                `DVF_OFS_ATTEN_A: next_state.attenA = regReq.wrData; // RULE1
                `DVF_OFS_ATTEN_B: next_state.attenB = regReq.wrData; // RULE1
                `DVF_OFS_SRC_CFG: next_state.srcCfg = regReq.wrData;
                `DVF_OFS_C2_LO: next_state.c2[7:0] = regReq.wrData; // RULE15
                `DVF_OFS_C2_HI: next_state.c2[15:8] = regReq.wrData; // RULE15
                `DVF_OFS_C3_LO: next_state.c3[7:0] = regReq.wrData; // RULE16
                `DVF_OFS_C3_HI: next_state.c3[15:8] = regReq.wrData; // RULE16
                `DVF_OFS_COEF_ADR: next_state.coefAdr = regReq.wrData;
                default: begin
                    // Byte lane of the full-scale word follows the address
                    if (regReq.addr >= `DVF_OFS_TRIM0 && regReq.addr <= `DVF_OFS_TRIM3) begin
                        next_state.trim[8*(regReq.addr - `DVF_OFS_TRIM0) +: 8] =
                            regReq.wrData; // RULE4
                    end
                end
            endcase
        end

        if (regReq.read) begin
            unique case (regReq.addr)
                `DVF_OFS_ATTEN_A: next_state.rdData = state.attenA;
                `DVF_OFS_ATTEN_B: next_state.rdData = state.attenB;
                `DVF_OFS_SRC_CFG: next_state.rdData = state.srcCfg;
                `DVF_OFS_C2_LO: next_state.rdData = state.c2[7:0];
                `DVF_OFS_C2_HI: next_state.rdData = state.c2[15:8];
                `DVF_OFS_C3_LO: next_state.rdData = state.c3[7:0];
                `DVF_OFS_C3_HI: next_state.rdData = state.c3[15:8];
                `DVF_OFS_COEF_ADR: next_state.rdData = state.coefAdr;
                default: begin
                    if (regReq.addr >= `DVF_OFS_TRIM0 && regReq.addr <= `DVF_OFS_TRIM3) begin
                        next_state.rdData = state.trim[8*(regReq.addr - `DVF_OFS_TRIM0) +: 8];
                    end else begin
                        next_state.rdData = 8'h00;
                    end
                end
            endcase
        end

        // Lowest numbered GPIO configured as selector wins
        for (int i = `DVF_NUM_GPIO - 1; i >= 0; i--) begin
            if (gpioCfg[i] == `DVF_GPIO_CFG_SRC) begin // RULE8 RULE9
                selHit = 1'b1;
                selLevel = state.pinSync[i];
            end
        end
        // Without a selector GPIO the low-level field stands
        field = (selHit && selLevel) ? state.srcCfg[`DVF_FLD_HIGH_LSB +: 2] // RULE7
                                     : state.srcCfg[`DVF_FLD_LOW_LSB +: 2]; // RULE6
        next_state.src = dvf_src_e'(field);
        next_state.byGpio = selHit;

        // Gains follow register changes one cycle later
        next_state.gainL = atten_gain(state.trim, swapChannels ? state.attenB
                                                                : state.attenA); // RULE2 RULE3
        next_state.gainR = atten_gain(state.trim, swapChannels ? state.attenA
                                                                : state.attenB); // RULE2 RULE3

        next_state.midValid = sampleIn.valid;
        if (sampleIn.valid) begin
            next_state.midL = apply_gain(sampleIn.left, state.gainL); // RULE21
            next_state.midR = apply_gain(sampleIn.right, state.gainR); // RULE21
        end
        next_state.out.valid = state.midValid;
        if (state.midValid) begin
            if (!thdBypass) begin
                next_state.out.left = thd_comp(state.midL, state.c2, state.c3); // RULE19
                next_state.out.right = thd_comp(state.midR, state.c2, state.c3); // RULE19
            end else if (state.src == DVF_SRC_DSD) begin
                // Bypassed compensation halves DSD to match its path gain
                next_state.out.left = state.midL >>> 1;
                next_state.out.right = state.midR >>> 1;
            end else begin
                next_state.out.left = state.midL;
                next_state.out.right = state.midR;
            end
        end

        if (coefWrite) begin
            next_state.coef.we = 1'b1; // RULE20
            next_state.coef.data = coefWrData; // RULE20
            next_state.coef.stage = state.coefAdr[`DVF_BIT_STAGE]; // RULE17
            next_state.coef.index = state.coefAdr[6:0]; // RULE18
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
            state.attenA <= `DVF_RST_ATTEN;
            state.attenB <= `DVF_RST_ATTEN;
            state.trim <= `DVF_RST_TRIM; // RULE3
            state.srcCfg <= `DVF_RST_SRC_CFG;
            state.c2 <= `DVF_RST_COEF;
            state.c3 <= `DVF_RST_COEF;
            state.coefAdr <= `DVF_RST_COEF_ADR;
            state.src <= DVF_SRC_I2S;
        end else begin
            state <= next_state;
        end
    end

    assign regRdData = state.rdData;
    assign coefWr = state.coef;
    assign selectedSource = state.src;
    assign sourceByGpio = state.byGpio;
    assign iirBypass = state.srcCfg[`DVF_BIT_IIR_SKIP]; // RULE11
    assign osfBypass = state.srcCfg[`DVF_BIT_OSF_SKIP]; // RULE12
    assign sampleOut = state.out;

    sequence s_src_write;
        regReq.write && regReq.addr == `DVF_OFS_SRC_CFG;
    endsequence

    sequence s_sample_in;
        sampleIn.valid;
    endsequence

    a_atten_write: assert property (@(posedge clk) disable iff (reset) // RULE1
        regReq.write && regReq.addr == `DVF_OFS_ATTEN_A |=> state.attenA == $past(regReq.wrData))
        else $error("attenuation A not stored");
    a_trim_top: assert property (@(posedge clk) disable iff (reset) // RULE4
        regReq.write && regReq.addr == `DVF_OFS_TRIM3 |=> state.trim[31:24] == $past(regReq.wrData))
        else $error("top byte of full-scale word misplaced");
    a_trim_reset: assert property (@(posedge clk) // RULE3
        !reset && $past(reset) |-> state.trim == `DVF_RST_TRIM)
        else $error("full-scale word reset value wrong");
    a_chan_map: assert property (@(posedge clk) disable iff (reset) // RULE2
        !swapChannels |=> state.gainL == atten_gain($past(state.trim), $past(state.attenA)))
        else $error("left gain not from attenuator A");
    a_iir_skip: assert property (@(posedge clk) disable iff (reset) // RULE11
        s_src_write |=> iirBypass == $past(regReq.wrData[`DVF_BIT_IIR_SKIP]))
        else $error("IIR skip not following bit 2");
    a_osf_skip: assert property (@(posedge clk) disable iff (reset) // RULE12
        s_src_write |=> osfBypass == $past(regReq.wrData[`DVF_BIT_OSF_SKIP]))
        else $error("oversampling skip not following bit 0");
    a_src_low: assert property (@(posedge clk) disable iff (reset) // RULE6 RULE8
        gpioCfg[0] == `DVF_GPIO_CFG_SRC && !state.pinSync[0]
        |=> selectedSource == dvf_src_e'($past(state.srcCfg[`DVF_FLD_LOW_LSB +: 2])))
        else $error("low pin level not choosing low field");
    a_src_high: assert property (@(posedge clk) disable iff (reset) // RULE7 RULE9
        gpioCfg[0] == `DVF_GPIO_CFG_SRC && state.pinSync[0]
        |=> selectedSource == dvf_src_e'($past(state.srcCfg[`DVF_FLD_HIGH_LSB +: 2])))
        else $error("high pin level not choosing high field");
    a_coef_target: assert property (@(posedge clk) disable iff (reset) // RULE17 RULE18 RULE20
        coefWrite |=> coefWr.we && coefWr.stage == $past(state.coefAdr[7])
                      && coefWr.index == $past(state.coefAdr[6:0]))
        else $error("custom coefficient target wrong");
    a_stream_lat: assert property (@(posedge clk) disable iff (reset) // RULE21
        s_sample_in |-> ##2 sampleOut.valid)
        else $error("sample not out two cycles later");
    a_thd_zero: assert property (@(posedge clk) disable iff (reset) // RULE19 RULE15 RULE16
        state.midValid && !thdBypass && state.c2 == 16'h0000 && state.c3 == 16'h0000
        |=> sampleOut.left == $past(state.midL))
        else $error("zero coefficients must leave samples unchanged");
endmodule : dvf_control
`default_nettype wire

// ==== sim/dvf_host_model.sv ====
// Host controller model that issues byte requests on the register port
// Assumes requests are taken on the rising clk edge and read data holds until the next read
`timescale 1ns/1ps
`default_nettype none
module dvf_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output var dvf_pkg::dvf_reg_req_s regReq,
    input wire logic [7:0] regRdData
);
    import dvf_pkg::*;
    initial regReq = '0;
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
        logic [7:0] v;
        v = d;
        if (a == 8'h15) v = d & 8'hf5;
        if (a == 8'h14) v = {1'b0, d[6:0]};
        @(posedge clk) regReq <= '{addr: a, wrData: v, write: !rd, read: rd};
        // Idle lines carry the inverse so a stale value never looks live
        @(posedge clk) regReq <= '{addr: ~a, wrData: ~v, write: 1'b0, read: 1'b0};
    endtask : xfer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(a, 8'h00, 1'b1);
        @(posedge clk) #1 d = regRdData;
    endtask : rd
endmodule : dvf_host_model
`default_nettype wire

// ==== sim/dvf_control_tb.sv ====
// Self-checking bench for the volume, source select and coefficient control slice
// Assumes dvf_pkg is compiled first and dvf_defs.svh is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "dvf_defs.svh"
module dvf_control_tb;
    import dvf_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    dvf_reg_req_s regReq;
    logic [7:0] regRdData, rv;
    logic swapChannels = 1'b0;
    logic thdBypass = 1'b1;
    logic [3:0] gpioCfg [`DVF_NUM_GPIO] = '{4'h0, 4'h0};
    logic [`DVF_NUM_GPIO-1:0] gpioPin = '0;
    logic [23:0] coefWrData = 24'h00_0000;
    logic coefWrite = 1'b0;
    dvf_coef_wr_s coefWr;
    dvf_src_e selectedSource;
    logic sourceByGpio, iirBypass, osfBypass;
    dvf_sample_s sampleIn = '0;
    dvf_sample_s sampleOut;
    logic [31:0] fsw;
    logic signed [15:0] c2w, c3w;
    logic dsdMode = 1'b0;
    int errTotal = 0;
    int checks = 0;
    initial forever #5 clk = ~clk;
    dvf_control dvf_control_inst (.clk(clk), .reset(reset), .regReq(regReq),
        .regRdData(regRdData), .swapChannels(swapChannels), .thdBypass(thdBypass),
        .gpioCfg(gpioCfg), .gpioPin(gpioPin), .coefWrData(coefWrData),
        .coefWrite(coefWrite), .coefWr(coefWr), .selectedSource(selectedSource),
        .sourceByGpio(sourceByGpio), .iirBypass(iirBypass), .osfBypass(osfBypass),
        .sampleIn(sampleIn), .sampleOut(sampleOut));
    dvf_host_model dvf_host_model_inst (.clk(clk), .regReq(regReq), .regRdData(regRdData));
    task automatic chkv(input logic [39:0] g, input logic [39:0] e);
        checks++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask : chkv
    task automatic chks(input logic [23:0] g, input logic [23:0] e);
        checks++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask : chks
    task automatic stopTest;
        $display("comparisons %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stopTest
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dvf_host_model_inst.xfer(a, d, 1'b0);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        dvf_host_model_inst.rd(a, rv);
        chkv(rv, e);
    endtask : rdc
    task automatic rst;
        if (!reset) @(posedge clk);
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        fsw = 32'h7fff_ffff;
        c2w = 16'h0000;
        c3w = 16'h0000;
    endtask : rst
    // Expected sample: gain table step 0 only, so codes must be multiples of 12
    function automatic logic [23:0] mdl(input logic [23:0] x, input logic [7:0] code);
        logic signed [63:0] g, a, s, c, y;
        g = ($signed({32'h0000_0000, fsw}) * 64'sh0_ffff) >>> 16;
        g = g >>> (code / 12);
        a = ($signed({{40{x[23]}}, x}) * g) >>> 31;
        s = (a * a) >>> 23;
        c = (s * a) >>> 23;
        y = thdBypass ? (dsdMode ? a >>> 1 : a) : a + ((s * c2w) >>> 15) + ((c * c3w) >>> 15);
        if (y > 64'sh7f_ffff) y = 64'sh7f_ffff;
        if (y < -64'sh80_0000) y = -64'sh80_0000;
        return y[23:0];
    endfunction : mdl
    task automatic test_reset_values;
        for (int a = 8'h0e; a <= 8'h1b; a++) begin
            rdc(8'(a), (a == 8'h14) ? 8'h7f : (a >= 8'h11 && a <= 8'h13) ? 8'hff : 8'h00);
        end
        chkv({selectedSource, sourceByGpio, iirBypass, osfBypass}, 5'h00);
        $display("reset values checked");
    endtask : test_reset_values
    task automatic test_readback;
        for (int a = 8'h0f; a <= 8'h1a; a++) wr(8'(a), 8'(a + 8'h60));
        for (int a = 8'h0f; a <= 8'h1a; a++) rdc(8'(a), 8'(a + 8'h60));
        chkv({selectedSource, iirBypass, osfBypass}, 4'hf);
        wr(8'h30, 8'h5a);
        rdc(8'h30, 8'h00);
        $display("register readback checked");
    endtask : test_readback
    task automatic pin(input logic [3:0] c0, input logic [3:0] c1, input logic [1:0] p,
                       input logic [2:0] e);
        @(posedge clk);
        gpioCfg <= '{c0, c1};
        gpioPin <= p;
        repeat (4) @(posedge clk);
        #1 chkv({selectedSource, sourceByGpio}, e);
    endtask : pin
    task automatic test_source;
        wr(8'h15, 8'hd5);
        @(posedge clk) #1 chkv({selectedSource, sourceByGpio, iirBypass, osfBypass}, 5'h0b);
        pin(4'h0, 4'h9, 2'b10, 3'h7);
        pin(4'h0, 4'h9, 2'b01, 3'h3);
        pin(4'h9, 4'h9, 2'b10, 3'h3);
        pin(4'h8, 4'h0, 2'b11, 3'h2);
        for (int c = 0; c < 4; c++) begin
            wr(8'h15, {2'(c), 2'(3 - c), 4'h0});
            pin(4'h9, 4'h0, 2'b01, {2'(c), 1'b1});
        end
        pin(4'h0, 4'h0, 2'b00, 3'h0);
        $display("source select checked");
    endtask : test_source
    task automatic test_coef;
        wr(8'h1a, 8'h85);
        @(posedge clk);
        coefWrite <= 1'b1;
        coefWrData <= 24'hab_cdef;
        @(posedge clk) coefWrData <= 24'h12_3456;
        #1 chkv(coefWr, {1'b1, 7'h05, 24'hab_cdef, 1'b1});
        @(posedge clk) coefWrite <= 1'b0;
        #1 chkv(coefWr, {1'b1, 7'h05, 24'h12_3456, 1'b1});
        @(posedge clk) #1 chkv(coefWr.we, 1'b0);
        wr(8'h1a, 8'h7f);
        @(posedge clk) coefWrite <= 1'b1;
        @(posedge clk) coefWrite <= 1'b0;
        #1 chkv(coefWr, {1'b0, 7'h7f, 24'h12_3456, 1'b1});
        $display("coefficient writes checked");
    endtask : test_coef
    task automatic send(input logic [23:0] x, input logic [7:0] cl, input logic [7:0] cr);
        @(posedge clk) sampleIn <= '{left: x, right: x, valid: 1'b1};
        @(posedge clk) sampleIn.valid <= 1'b0;
        #1 chkv(sampleOut.valid, 1'b0);
        @(posedge clk) #1 chkv(sampleOut.valid, 1'b1);
        chks(sampleOut.left, mdl(x, cl));
        chks(sampleOut.right, mdl(x, cr));
        @(posedge clk) #1 chkv(sampleOut.valid, 1'b0);
    endtask : send
    task automatic test_stream;
        wr(8'h10, 8'h0c);
        send(24'h40_0000, 8'd0, 8'd12);
        @(posedge clk) swapChannels <= 1'b1;
        send(24'h40_0000, 8'd12, 8'd0);
        wr(8'h0f, 8'hf0);
        send(24'h7f_ffff, 8'd12, 8'd240);
        @(posedge clk) swapChannels <= 1'b0;
        for (int i = 0; i < 3; i++) wr(8'(8'h11 + i), 8'h00);
        wr(8'h14, 8'h40);
        wr(8'h0f, 8'h00);
        wr(8'h10, 8'h00);
        fsw = 32'h4000_0000;
        @(posedge clk) thdBypass <= 1'b0;
        send(24'h60_0000, 8'd0, 8'd0);
        wr(8'h17, 8'h40);
        wr(8'h19, 8'he0);
        c2w = 16'h4000;
        c3w = 16'he000;
        @(posedge clk) thdBypass <= 1'b0;
        send(24'h60_0000, 8'd0, 8'd0);
        // Base-rate samples only, so the 8x interpolator stays in the path
        wr(8'h15, 8'h30);
        dsdMode = 1'b1;
        @(posedge clk) thdBypass <= 1'b1;
        #1 chkv(selectedSource, 2'h3);
        send(24'h60_0000, 8'd0, 8'd0);
        dsdMode = 1'b0;
        $display("sample path checked");
    endtask : test_stream
    initial begin
        rst;
        test_reset_values;
        test_readback;
        rst;
        test_reset_values;
        test_source;
        test_coef;
        test_stream;
        stopTest;
    end
    // The whole sequence needs about three hundred cycles; twenty thousand means a hang
    initial begin
        #200000;
        errTotal++;
        stopTest;
    end
endmodule : dvf_control_tb
`default_nettype wire
